/* core/scd_cfg.svh */
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// APB register byte addresses
`define SCD_A_CTRL 8'h00
`define SCD_A_RES 8'h04
`define SCD_A_CUR 8'h08
`define SCD_A_STAT 8'h0c
`define SCD_A_POS 8'h10
`define SCD_A_CNT 8'h14

// Control register bit positions
`define SCD_B_MODE 0
`define SCD_B_EDGE 1
`define SCD_B_ENPOL 2
`define SCD_B_SWCFG 3

// Reset values and legal ranges
`define SCD_CTRL_RST 4'h0
`define SCD_RES_MIN 17'h000c8
`define SCD_RES_MAX 17'h19000
`define SCD_RES_RST 17'h000c8
`define SCD_CUR_MIN 7'h05
`define SCD_CUR_MAX 7'h53
`define SCD_CUR_RST 7'h20

// Idle current reduction, 60 percent as three fifths
`define SCD_IDLE_NUM 10'h003
`define SCD_IDLE_DEN 10'h005
`define SCD_IDLE_TIME_S 1
`define SCD_CLK_MHZ 250
`define SCD_IDLE_CYC (`SCD_IDLE_TIME_S * `SCD_CLK_MHZ * 1000000)

// Switch field positions
`define SCD_SW_RES_HI 7
`define SCD_SW_RES_LO 4
`define SCD_SW_STAND 3
`define SCD_SW_CUR_HI 2
`define SCD_SW_CUR_LO 0

`endif

/* core/scd_pkg.sv */
`default_nettype none
package scd_pkg;

  // Command decoding mode
  typedef enum logic {
    SCD_MODE_PULDIR = 1'b0,
    SCD_MODE_DBLPULSE = 1'b1
  } scd_mode_e;

  // Active edge of the pulse inputs
  typedef enum logic {
    SCD_EDGE_RISE = 1'b0,
    SCD_EDGE_FALL = 1'b1
  } scd_edge_e;

  typedef logic [16:0] scd_res_t;
  typedef logic [6:0] scd_cur_t;

  // Whole state of the decoder core
  typedef struct packed {
    logic [3:0] ctrl;
    scd_res_t res;
    scd_cur_t cur;
    logic stp_d;
    logic dir_d;
    logic step;
    logic ccw;
    logic en;
    scd_res_t pos;
    logic [31:0] cnt;
    scd_res_t res_o;
    scd_cur_t cur_o;
    logic [31:0] rdata;
    logic ctrl_seen;
  } scd_core_s;

  // Synchroniser state
  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
  } scd_sync_s;

  // Idle timer state
  typedef struct packed {
    logic [27:0] cnt;
    logic idle;
  } scd_idle_s;

endpackage
`default_nettype wire

/* core/scd_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_sync
  import scd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [10:0] async_in,
  output logic [10:0] sync_out
);

  scd_sync_s s_reg;
  scd_sync_s s_next;

  // Two flip-flop stages, first read only by second
  always_comb begin
    s_next = s_reg;
    s_next.s1 = async_in;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.s2;

  sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> sync_out == $past(async_in, 2))
    else $error("synchroniser output not two cycles behind input");

endmodule
`default_nettype wire

/* core/scd_idle.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scd_cfg.svh"
module scd_idle
  import scd_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `SCD_IDLE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic activity,
  output logic idle
);

  scd_idle_s s_reg;
  scd_idle_s s_next;

  // Quiet time counter, restarted by every step pulse
  always_comb begin
    s_next = s_reg;
    if (activity) begin
      s_next.cnt = '0;
      s_next.idle = 1'b0;
    end else if (s_reg.cnt == 28'(IDLE_CYCLES - 1)) begin
      s_next.idle = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 28'h0000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign idle = s_reg.idle;

  idle_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    activity |=> !idle)
    else $error("idle flag survived a step pulse");

  idle_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(idle) |-> $past(s_reg.cnt) == 28'(IDLE_CYCLES - 1))
    else $error("idle flag rose before the quiet time ran out");

endmodule
`default_nettype wire

/* core/scd_top.sv */
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "scd_cfg.svh"

// How it works
// - Pulse/direction mode steps once per active step edge, rising or falling.
// - Double-pulse mode takes step input edges as clockwise steps.
// - Pulse/direction mode takes direction level as rotation direction.
// - Double-pulse mode takes direction input edges as counter-clockwise steps.
// - Enable level gates steps; polarity selectable; by default a low input means disabled.
// - Reset defaults are pulse/direction mode with rising active edge.
// - Resolution is held within 200 to 102400 steps per revolution.
// - Running current is held within 0.5A to 8.3A.
// - Outside software mode the switch sets resolution and current.
// - Exactly three command inputs: step, direction, enable, driven outside.
// - After one second without pulses current drops to sixty percent, or to half if the switch sets it and the standstill switch is off.
// - Upper four switches select resolution; all on keeps software value.
module scd_top
  import scd_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `SCD_IDLE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_pulse_in,
  input wire logic direction_in,
  input wire logic drive_enable_in,
  input wire logic [7:0] dip_switch_in,
  output logic step_out,
  output logic step_ccw_out,
  output logic drive_en_out,
  output logic [16:0] res_out,
  output logic [16:0] micro_pos_out,
  output logic [6:0] cur_out,
  output logic idle_out
);

  scd_core_s s_reg;
  scd_core_s s_next;

  logic [10:0] sync_q;
  logic stp_s;
  logic dir_s;
  logic en_pin_s;
  logic [7:0] sw_s;
  logic idle;

  // Switch lookup: off-pattern of the upper four switches
  function automatic scd_res_t sw_res_lut(input logic [3:0] idx);
    scd_res_t r;
    r = `SCD_RES_RST;
    case (idx)
      4'h1: r = 17'h00190;
      4'h2: r = 17'h00320;
      4'h3: r = 17'h00640;
      4'h4: r = 17'h00c80;
      4'h5: r = 17'h01900;
      4'h6: r = 17'h03200;
      4'h7: r = 17'h06400;
      4'h8: r = 17'h003e8;
      4'h9: r = 17'h007d0;
      4'ha: r = 17'h00fa0;
      4'hb: r = 17'h01388;
      4'hc: r = 17'h01f40;
      4'hd: r = 17'h02710;
      4'he: r = 17'h04e20;
      4'hf: r = 17'h061a8;
      default: r = `SCD_RES_RST;
    endcase
    return r;
  endfunction

  // Switch lookup: peak current in tenths of an ampere
  function automatic scd_cur_t sw_cur_lut(input logic [2:0] idx);
    scd_cur_t c;
    c = `SCD_CUR_RST;
    case (idx)
      3'h1: c = 7'h20;
      3'h2: c = 7'h28;
      3'h3: c = 7'h31;
      3'h4: c = 7'h39;
      3'h5: c = 7'h40;
      3'h6: c = 7'h49;
      3'h7: c = 7'h53;
      default: c = `SCD_CUR_RST;
    endcase
    return c;
  endfunction

  // Pins into the clock domain, command inputs and switches alike
  scd_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({dip_switch_in, drive_enable_in, direction_in,
               step_pulse_in}),
    .sync_out(sync_q)
  );

  assign stp_s = sync_q[0];
  assign dir_s = sync_q[1];
  assign en_pin_s = sync_q[2];
  assign sw_s = sync_q[10:3];

  // Configuration fields
  logic dbl_mode;
  logic fall_edge;
  logic use_sw;
  assign dbl_mode = s_reg.ctrl[`SCD_B_MODE] == SCD_MODE_DBLPULSE;
  assign fall_edge = s_reg.ctrl[`SCD_B_EDGE] == SCD_EDGE_FALL;
  assign use_sw = !s_reg.ctrl[`SCD_B_SWCFG];

  // Active edge detection on synchronised inputs
  logic stp_act;
  logic dir_act;
  assign stp_act = fall_edge ? (s_reg.stp_d & ~stp_s)
                             : (stp_s & ~s_reg.stp_d);
  assign dir_act = fall_edge ? (s_reg.dir_d & ~dir_s)
                             : (dir_s & ~s_reg.dir_d);

  // Enable level with selectable polarity
  logic enabled;
  assign enabled = s_reg.ctrl[`SCD_B_ENPOL] ? !en_pin_s : en_pin_s;

  // Step decode per mode
  logic step_ev;
  logic ccw_ev;
  always_comb begin
    if (dbl_mode) begin
      step_ev = enabled & (stp_act ^ dir_act);
      ccw_ev = dir_act & ~stp_act;
    end else begin
      step_ev = enabled & stp_act;
      ccw_ev = dir_s;
    end
  end

  // Pulse activity for the idle timer, enabled or not
  logic activity;
  assign activity = stp_act | (dbl_mode & dir_act);

  scd_idle #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .activity(activity),
    .idle(idle)
  );

  // Resolution and current in force
  logic [3:0] sw_res_idx;
  logic [2:0] sw_cur_idx;
  scd_res_t eff_res;
  scd_cur_t eff_cur;
  scd_cur_t idle_cur;
  logic [9:0] cur_prod;
  assign sw_res_idx = ~sw_s[`SCD_SW_RES_HI:`SCD_SW_RES_LO];
  assign sw_cur_idx = sw_s[`SCD_SW_CUR_HI:`SCD_SW_CUR_LO];
  assign eff_res = (use_sw && sw_res_idx != 4'h0)
                 ? sw_res_lut(sw_res_idx) : s_reg.res;
  assign eff_cur = (use_sw && sw_cur_idx != 3'h0)
                 ? sw_cur_lut(sw_cur_idx) : s_reg.cur;
  assign cur_prod = ({3'h0, eff_cur} * `SCD_IDLE_NUM) / `SCD_IDLE_DEN;

  // Standstill: half outside software mode with the standstill switch off, else sixty percent
  always_comb begin
    if (use_sw && !sw_s[`SCD_SW_STAND]) begin
      idle_cur = eff_cur >> 1;
    end else begin
      idle_cur = cur_prod[6:0];
    end
  end

  // APB decode
  logic setup;
  logic access;
  logic addr_ok;
  logic wr;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  always_comb begin
    case (paddr)
      `SCD_A_CTRL, `SCD_A_RES, `SCD_A_CUR,
      `SCD_A_STAT, `SCD_A_POS, `SCD_A_CNT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign wr = access & pwrite & addr_ok;

  // Written values held in their legal ranges
  scd_res_t wres;
  scd_cur_t wcur;
  always_comb begin
    if (pwdata[31:17] != 15'h0000 || pwdata[16:0] > `SCD_RES_MAX) begin
      wres = `SCD_RES_MAX;
    end else if (pwdata[16:0] < `SCD_RES_MIN) begin
      wres = `SCD_RES_MIN;
    end else begin
      wres = pwdata[16:0];
    end
    if (pwdata[31:7] != 25'h0000000 || pwdata[6:0] > `SCD_CUR_MAX) begin
      wcur = `SCD_CUR_MAX;
    end else if (pwdata[6:0] < `SCD_CUR_MIN) begin
      wcur = `SCD_CUR_MIN;
    end else begin
      wcur = pwdata[6:0];
    end
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.stp_d = stp_s;
    s_next.dir_d = dir_s;
    s_next.step = step_ev;
    s_next.en = enabled;
    s_next.res_o = eff_res;
    s_next.cur_o = idle ? idle_cur : eff_cur;
    if (step_ev) begin
      s_next.ccw = ccw_ev;
    end
    // Microstep position wraps at the resolution in force
    if (step_ev && ccw_ev) begin
      s_next.pos = (s_reg.pos == 17'h00000) ? eff_res - 17'h00001
                                             : s_reg.pos - 17'h00001;
      s_next.cnt = s_reg.cnt - 32'h00000001;
    end else if (step_ev) begin
      s_next.pos = (s_reg.pos >= eff_res - 17'h00001) ? 17'h00000
                                                       : s_reg.pos + 17'h00001;
      s_next.cnt = s_reg.cnt + 32'h00000001;
    end
    // Register writes at the access phase
    if (wr) begin
      case (paddr)
        `SCD_A_CTRL: begin
          s_next.ctrl = pwdata[3:0];
          s_next.ctrl_seen = 1'b1;
        end
        `SCD_A_RES: s_next.res = wres;
        `SCD_A_CUR: s_next.cur = wcur;
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    // Read data captured in the setup phase
    if (setup) begin
      case (paddr)
        `SCD_A_CTRL: s_next.rdata = {28'h0000000, s_reg.ctrl};
        `SCD_A_RES: s_next.rdata = {15'h0000, s_reg.res};
        `SCD_A_CUR: s_next.rdata = {25'h0000000, s_reg.cur};
        `SCD_A_STAT: s_next.rdata = {20'h00000, idle, s_reg.ccw,
                                     s_reg.en, use_sw, sw_s};
        `SCD_A_POS: s_next.rdata = {15'h0000, s_reg.pos};
        `SCD_A_CNT: s_next.rdata = s_reg.cnt;
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= `SCD_CTRL_RST;
      s_reg.res <= `SCD_RES_RST;
      s_reg.cur <= `SCD_CUR_RST;
      s_reg.res_o <= `SCD_RES_RST;
      s_reg.cur_o <= `SCD_CUR_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign step_out = s_reg.step;
  assign step_ccw_out = s_reg.ccw;
  assign drive_en_out = s_reg.en;
  assign res_out = s_reg.res_o;
  assign micro_pos_out = s_reg.pos;
  assign cur_out = s_reg.cur_o;
  assign idle_out = idle;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pd_step_a: assert property (
    (!dbl_mode && enabled && stp_act) |=> step_out)
    else $error("missed step in pulse/direction mode");

  dp_cw_a: assert property (
    (dbl_mode && enabled && stp_act && !dir_act)
    |=> step_out && !step_ccw_out)
    else $error("clockwise pulse not taken");

  pd_dir_a: assert property (
    (!dbl_mode && step_ev) |=> step_ccw_out == $past(dir_s))
    else $error("direction level not followed");

  dp_ccw_a: assert property (
    (dbl_mode && enabled && dir_act && !stp_act)
    |=> step_out && step_ccw_out)
    else $error("counter-clockwise pulse not taken");

  en_gate_a: assert property (
    !enabled |=> !step_out && !drive_en_out)
    else $error("step passed while disabled");

  reset_mode_a: assert property (
    !s_reg.ctrl_seen |-> !dbl_mode && !fall_edge)
    else $error("default mode is not pulse/direction rising");

  res_range_a: assert property (
    res_out >= `SCD_RES_MIN && res_out <= `SCD_RES_MAX)
    else $error("resolution out of range");

  cur_range_a: assert property (
    !idle |=> !idle |-> cur_out >= `SCD_CUR_MIN && cur_out <= `SCD_CUR_MAX)
    else $error("running current out of range");

  sw_res_a: assert property (
    (use_sw && sw_res_idx != 4'h0) |=> res_out == $past(eff_res)
    && res_out != $past(s_reg.res) || $past(eff_res) == $past(s_reg.res))
    else $error("switch resolution not applied");

  sw_keep_a: assert property (
    (sw_res_idx == 4'h0) |=> res_out == $past(s_reg.res))
    else $error("all-on switches did not keep stored resolution");

  idle_cur_a: assert property (
    (idle && !(use_sw && !sw_s[`SCD_SW_STAND]))
    |=> cur_out == $past(cur_prod[6:0]))
    else $error("idle current not reduced to sixty percent");

  cv_pd_step_c: cover property (!dbl_mode && step_out);
  cv_dp_ccw_c: cover property (dbl_mode && step_out && step_ccw_out);
  cv_idle_c: cover property ($rose(idle_out));
  cv_wrap_c: cover property (step_out && micro_pos_out == 17'h00000);

endmodule
`default_nettype wire

/* verification/scd_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Motion controller that drives the three command lines
module scd_ctl_model (
  input wire logic pclk,
  output logic step_pulse_in,
  output logic direction_in,
  output logic drive_enable_in
);
  // Lines idle low, drive enabled, from time zero
  initial begin
    step_pulse_in = 1'b0;
    direction_in = 1'b0;
    drive_enable_in = 1'b1;
  end
  // New step and direction levels, held five cycles
  task automatic drive(input logic s, input logic d);
    @(posedge pclk);
    step_pulse_in <= s;
    direction_in <= d;
    repeat (5) @(posedge pclk);
  endtask
  // New enable level, held five cycles
  task automatic enable(input logic e);
    @(posedge pclk);
    drive_enable_in <= e;
    repeat (5) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* verification/scd_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scd_cfg.svh"
// Bench for the command decoder
module scd_top_tb_top;
  import scd_pkg::*;
  localparam int IDLE = 20;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic step_pulse_in, direction_in, drive_enable_in;
  logic [7:0] dip_switch_in;
  logic step_out, step_ccw_out, drive_en_out, idle_out;
  logic [16:0] res_out, micro_pos_out;
  logic [6:0] cur_out;
  int err_count = 0;
  int checks_done = 0;
  int nsteps = 0;
  int cyc = 0;
  int pin_cyc = 0;
  int step_cyc = 0;
  logic last_pin = 1'b0;

  // 250 MHz clock
  always #2 pclk = ~pclk;

  scd_top #(.IDLE_CYCLES(IDLE)) i_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .step_pulse_in, .direction_in, .drive_enable_in, .dip_switch_in,
    .step_out, .step_ccw_out, .drive_en_out, .res_out, .micro_pos_out,
    .cur_out, .idle_out);
  scd_ctl_model i_ctl (.pclk, .step_pulse_in, .direction_in,
    .drive_enable_in);

  // Counts step cycles and times pin edges against steps
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    last_pin <= step_pulse_in;
    if (step_pulse_in !== last_pin) pin_cyc <= cyc;
    if (step_out === 1'b1) nsteps <= nsteps + 1;
    if (step_out === 1'b1) step_cyc <= cyc;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang;
    err_count++;
    $display("ERROR t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
    test_done();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (n == 50) hang();
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic e;
    chk(32'(cur_out), 32'h20);
    chk(32'(res_out), 32'hc8);
    rdchk(`SCD_A_CTRL, 32'h0);
    rdchk(`SCD_A_RES, 32'hc8);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    $display("t_reset done");
  endtask

  // Both active edges, then direction levels
  task automatic t_puldir;
    int n0;
    for (int f = 1; f >= 0; f--) begin
      wr(`SCD_A_CTRL, 32'h8 | (f << 1));
      n0 = nsteps;
      i_ctl.drive(1'b1, 1'b0);
      chk(nsteps - n0, 32'(1 - f));
      i_ctl.drive(1'b0, 1'b0);
      chk(nsteps - n0, 32'h1);
    end
    n0 = nsteps;
    i_ctl.drive(1'b1, 1'b0);
    chk(step_cyc - pin_cyc, 32'h3);
    i_ctl.drive(1'b0, 1'b1);
    i_ctl.drive(1'b1, 1'b1);
    chk(32'(step_ccw_out), 32'h1);
    i_ctl.drive(1'b0, 1'b0);
    i_ctl.drive(1'b1, 1'b0);
    chk(32'(step_ccw_out), 32'h0);
    i_ctl.drive(1'b0, 1'b0);
    chk(nsteps - n0, 32'h3);
    chk(32'(micro_pos_out), 32'h3);
    rdchk(`SCD_A_POS, 32'h3);
    rdchk(`SCD_A_CNT, 32'h3);
    $display("t_puldir done");
  endtask

  task automatic t_double;
    int n0;
    wr(`SCD_A_CTRL, 32'h9);
    n0 = nsteps;
    i_ctl.drive(1'b1, 1'b0);
    chk(nsteps - n0, 32'h1);
    chk(32'(step_ccw_out), 32'h0);
    i_ctl.drive(1'b0, 1'b0);
    i_ctl.drive(1'b0, 1'b1);
    chk(nsteps - n0, 32'h2);
    chk(32'(step_ccw_out), 32'h1);
    i_ctl.drive(1'b0, 1'b0);
    $display("t_double done");
  endtask

  task automatic t_enable;
    int n0;
    wr(`SCD_A_CTRL, 32'h8);
    i_ctl.enable(1'b0);
    chk(32'(drive_en_out), 32'h0);
    n0 = nsteps;
    i_ctl.drive(1'b1, 1'b0);
    i_ctl.drive(1'b0, 1'b0);
    chk(nsteps - n0, 32'h0);
    wr(`SCD_A_CTRL, 32'hc);
    repeat (3) @(posedge pclk);
    chk(32'(drive_en_out), 32'h1);
    i_ctl.enable(1'b1);
    chk(32'(drive_en_out), 32'h0);
    wr(`SCD_A_CTRL, 32'h8);
    repeat (3) @(posedge pclk);
    chk(32'(drive_en_out), 32'h1);
    $display("t_enable done");
  endtask

  task automatic t_clamp;
    wr(`SCD_A_RES, 32'h64);
    rdchk(`SCD_A_RES, 32'hc8);
    wr(`SCD_A_RES, 32'h30d40);
    rdchk(`SCD_A_RES, 32'h19000);
    wr(`SCD_A_RES, 32'h400);
    rdchk(`SCD_A_RES, 32'h400);
    wr(`SCD_A_CUR, 32'h1);
    rdchk(`SCD_A_CUR, 32'h5);
    wr(`SCD_A_CUR, 32'h64);
    rdchk(`SCD_A_CUR, 32'h53);
    wr(`SCD_A_CUR, 32'h32);
    i_ctl.drive(1'b1, 1'b0);
    i_ctl.drive(1'b0, 1'b0);
    chk(32'(res_out), 32'h400);
    chk(32'(cur_out), 32'h32);
    $display("t_clamp done");
  endtask

  // Sets the switches, wakes the drive, checks outputs
  task automatic sw(input logic [7:0] v, input logic [31:0] r,
    input logic [31:0] c);
    @(posedge pclk);
    dip_switch_in <= v;
    i_ctl.drive(1'b1, 1'b0);
    i_ctl.drive(1'b0, 1'b0);
    chk(32'(res_out), r);
    chk(32'(cur_out), c);
  endtask

  task automatic t_switch;
    wr(`SCD_A_CTRL, 32'h0);
    sw(8'he8, 32'h190, 32'h32);
    sw(8'h08, 32'h61a8, 32'h32);
    sw(8'hfb, 32'h400, 32'h31);
    rdchk(`SCD_A_STAT, 32'h3fb);
    $display("t_switch done");
  endtask

  task automatic t_idle;
    int n;
    n = 0;
    wr(`SCD_A_CTRL, 32'h8);
    i_ctl.drive(1'b1, 1'b0);
    i_ctl.drive(1'b0, 1'b0);
    chk(32'(idle_out), 32'h0);
    while (idle_out !== 1'b1) begin
      if (n == 100) hang();
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    chk(32'(cur_out), 32'h1e);
    dip_switch_in <= 8'hf1;
    wr(`SCD_A_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk(32'(cur_out), 32'h10);
    $display("t_idle done");
  endtask

  // Reset for four cycles, then the scenarios
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dip_switch_in = 8'hf0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_puldir();
    t_double();
    t_enable();
    t_clamp();
    t_switch();
    t_idle();
    test_done();
  end
endmodule
`default_nettype wire
